// File: wide_access_regs.vh
// Address map and reset values for the 16-bit wide register access bridge.
// Assumes an 8-bit CPU data bus with byte addresses local to this block.
`ifndef WIDE_ACCESS_REGS_VH
`define WIDE_ACCESS_REGS_VH

`define ADDR_W 2
`define ADDR_LOW 2'h0
`define ADDR_HIGH 2'h1
`define ADDR_TEMP 2'h2
`define WIDE_RESET 16'h0000
`define TEMP_RESET 8'h00
`define LOW_LSB 0
`define HIGH_LSB 8

`endif

// File: wide_register_byte_access.v
// Bridge giving an 8-bit bus atomic access to one 16-bit register via a shared temp byte.
// Assumes a single-cycle CPU byte access strobe on clk; peripheral side is on the same clock.
//
// What this block does
// R01: 16-bit register reaches the 8-bit bus through a temp byte with 16-bit path.
// R02: Bus master writes low byte first, then high byte, as two byte accesses.
// R03: Low byte write goes into temp register, target register unchanged.
// R04: High byte write updates high byte and copies temp into low byte together.
// R05: Bus master reads low byte first, then high byte, as two byte accesses.
// R06: Low byte read returns live low byte and captures high byte into temp.
// R07: High byte read returns temp register contents, not live high byte.
// R08: Software may read and write the temp register directly.
// R09: Software should mask interrupts around two-byte accesses to the same register.
// R10: Temp holds until next low access or direct write; orphan high write commits it.
`include "wide_access_regs.vh"

module wide_register_byte_access (
	input wire clk,
	input wire sys_rst,
	input wire bus_sel,
	input wire bus_wr,
	input wire [`ADDR_W-1:0] bus_addr,
	input wire [7:0] bus_wdata,
	output reg [7:0] bus_rdata,
	output reg bus_rvalid,
	input wire periph_load,
	input wire [15:0] periph_wdata,
	output reg [15:0] periph_value,
	output reg periph_commit
);

	// Decoded byte access strobes
	wire wr;
	wire rd;
	wire wr_low;
	wire wr_high;
	wire wr_temp;
	wire rd_low;
	wire rd_high;
	wire rd_temp;
	wire rd_none;

	// Shared temp byte and the next values of every register
	reg [7:0] temp;
	reg [15:0] next_value;
	reg [7:0] next_temp;
	reg [7:0] next_rdata;
	reg next_rvalid;
	reg next_commit;

	// True when the address selects the given byte location
	function addr_hit;
		input [`ADDR_W-1:0] addr;
		input [`ADDR_W-1:0] code;
		begin
			addr_hit = (addr == code);
		end
	endfunction

	// One byte lane of the wide register
	function [7:0] byte_lane;
		input [15:0] word;
		input hi;
		begin
			if (hi) begin
				byte_lane = word[`HIGH_LSB +: 8];
			end else begin
				byte_lane = word[`LOW_LSB +: 8];
			end
		end
	endfunction

	// High byte and low byte joined into one wide word
	function [15:0] join_bytes;
		input [7:0] hi;
		input [7:0] lo;
		begin
			join_bytes = {hi, lo};
		end
	endfunction

	// Wide register: a bus high write wins over a peripheral load
	function [15:0] pick_value;
		input [15:0] cur;
		input [15:0] load_data;
		input load;
		input [7:0] high_data;
		input [7:0] low_data;
		input commit;
		begin
			pick_value = cur;
			if (commit) begin
				pick_value = join_bytes(high_data, low_data); // R01 R04 R10
			end else if (load) begin
				pick_value = load_data;
			end
		end
	endfunction

	// Temp byte: low write, direct write or low read snapshot
	// A second master between the two halves would overwrite it
	function [7:0] pick_temp;
		input [7:0] cur;
		input [7:0] wdata;
		input [15:0] value;
		input low_wr;
		input direct_wr;
		input low_rd;
		begin
			pick_temp = cur;
			if (low_wr) begin
				pick_temp = wdata; // R03 R10
			end else if (direct_wr) begin
				pick_temp = wdata; // R08
			end else if (low_rd) begin
				pick_temp = byte_lane(value, 1'b1); // R01 R06
			end
		end
	endfunction

	// Read data: live low byte, temp for high and direct reads
	function [7:0] pick_rdata;
		input [7:0] cur_temp;
		input [15:0] value;
		input low_rd;
		input high_rd;
		input temp_rd;
		input none_rd;
		begin
			pick_rdata = 8'h00;
			if (low_rd) begin
				pick_rdata = byte_lane(value, 1'b0); // R06
			end else if (high_rd) begin
				pick_rdata = cur_temp; // R07
			end else if (temp_rd) begin
				pick_rdata = cur_temp; // R08
			end else if (none_rd) begin
				pick_rdata = 8'h00;
			end
		end
	endfunction

	assign wr = bus_sel & bus_wr;
	assign rd = bus_sel & ~bus_wr;
	assign wr_low = wr & addr_hit(bus_addr, `ADDR_LOW);
	assign wr_high = wr & addr_hit(bus_addr, `ADDR_HIGH);
	assign wr_temp = wr & addr_hit(bus_addr, `ADDR_TEMP);
	assign rd_low = rd & addr_hit(bus_addr, `ADDR_LOW);
	assign rd_high = rd & addr_hit(bus_addr, `ADDR_HIGH);
	assign rd_temp = rd & addr_hit(bus_addr, `ADDR_TEMP);
	assign rd_none = rd & ~rd_low & ~rd_high & ~rd_temp;

	// Next wide register value
	always @* begin
		next_value = pick_value(periph_value, periph_wdata, periph_load,
			bus_wdata, temp, wr_high);
	end

	// Next temp byte
	always @* begin
		next_temp = pick_temp(temp, bus_wdata, periph_value,
			wr_low, wr_temp, rd_low);
	end

	// Next read data
	always @* begin
		next_rdata = pick_rdata(temp, periph_value, rd_low, rd_high, rd_temp, rd_none);
	end

	// Read strobe answered one cycle later, unmapped reads too
	always @* begin
		next_rvalid = rd;
	end

	// Commit pulse follows every high byte write
	always @* begin
		next_commit = wr_high; // R04
	end

	// Wide register
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			periph_value <= `WIDE_RESET;
		end else begin
			periph_value <= next_value;
		end
	end

	// Shared temp byte
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			temp <= `TEMP_RESET;
		end else begin
			temp <= next_temp;
		end
	end

	// Read data straight from a flip-flop
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_rdata <= 8'h00;
		end else begin
			bus_rdata <= next_rdata;
		end
	end

	// Read answer strobe
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= next_rvalid;
		end
	end

	// Commit pulse
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			periph_commit <= 1'b0;
		end else begin
			periph_commit <= next_commit;
		end
	end

endmodule

// File: wrba_properties.sv
// Checker on the bridge ports
// Assumes bound to the design top
module wrba_chk(input wire clk, input wire sys_rst, input wire bus_sel,
	input wire bus_wr, input wire [1:0] bus_addr, input wire [7:0] bus_wdata,
	input wire [7:0] bus_rdata, input wire bus_rvalid, input wire periph_load,
	input wire [15:0] periph_value, input wire periph_commit);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence rd_lo; bus_sel && !bus_wr && bus_addr == 2'h0; endsequence
	sequence rd_hi; bus_sel && !bus_wr && bus_addr == 2'h1; endsequence
	sequence rd_tmp; bus_sel && !bus_wr && bus_addr == 2'h2; endsequence
	sequence wr_hi; bus_sel && bus_wr && bus_addr == 2'h1; endsequence
	sequence wr_tmp; bus_sel && bus_wr && bus_addr == 2'h2; endsequence
	a_low_hold: assert property (bus_sel && bus_wr && bus_addr == 0 && !periph_load
		|=> $stable(periph_value)) else $error("low write moved value");
	a_high_commit: assert property (wr_hi |=> periph_commit
		&& periph_value[15:8] == $past(bus_wdata)) else $error("bad commit");
	a_pair_read: assert property (rd_lo ##1 rd_hi
		|=> bus_rdata == $past(periph_value[15:8], 2)) else $error("bad high read");
	a_gap_read: assert property (rd_lo ##1 !bus_sel ##1 rd_hi
		|=> bus_rdata == $past(periph_value[15:8], 3)) else $error("bad spaced high read");
	a_low_read: assert property (rd_lo
		|=> bus_rvalid && bus_rdata == $past(periph_value[7:0])) else $error("bad low read");
	a_temp_read: assert property (wr_tmp ##1 !bus_sel ##1 rd_tmp
		|=> bus_rdata == $past(bus_wdata, 3)) else $error("bad temp read");
	a_commit_cause: assert property (periph_commit
		|-> $past(bus_sel && bus_wr && bus_addr == 2'h1)) else $error("stray commit");
endmodule
bind wide_register_byte_access wrba_chk wrba_chk_inst(.*);

// File: cpu_model.sv
// CPU byte access model
// Assumes one strobe per access
module cpu_model(output logic sel, output logic wr, output logic [1:0] a,
	output logic [7:0] d, input wire clk);
	timeunit 1ns;
	timeprecision 1ps;
	initial {sel, wr, a, d} = 0;
	task acc(input logic w, input logic [1:0] x, input logic [7:0] v);
		@(posedge clk) #1 {sel, wr, a, d} = {1'b1, w, x, v};
		@(posedge clk) #1 sel = 0;
	endtask
endmodule

// File: wide_register_byte_access_tb.sv
// Bench for the byte bridge
// Assumes cpu_model drives the bus
module wide_register_byte_access_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, sys_rst = 1, s, w, rv, pc, pl = 0;
	logic [1:0] a;
	logic [7:0] d, rd, q[$];
	logic [15:0] pv, pw = 16'h0000;
	logic [31:0] r = 32'hb95db1ae;
	int n_mismatch = 0, checks = 0;
	always #4 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], ^(x & 32'h80200003)};
	endfunction
	cpu_model cpu_model_inst(.sel(s), .wr(w), .a(a), .d(d), .clk(clk));
	wide_register_byte_access wide_register_byte_access_inst(.clk(clk), .sys_rst(sys_rst),
		.bus_sel(s), .bus_wr(w), .bus_addr(a), .bus_wdata(d), .bus_rdata(rd),
		.bus_rvalid(rv), .periph_load(pl), .periph_wdata(pw),
		.periph_value(pv), .periph_commit(pc));
	task cmp(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %0t %h %h", $time, g, e);
		end
	endtask
	task conclude;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) if (rv === 1'b1) cmp(rd, q.pop_front());
	initial begin
		repeat (20) @(posedge clk);
		#1 sys_rst = 0;
		repeat (4) begin
			r = lfsr(r);
			cpu_model_inst.acc(1, 0, r[7:0]);
			cpu_model_inst.acc(1, 1, r[15:8]);
			cmp(pv, r[15:0]);
			cmp(pc, 1'b1);
			q = {q, r[7:0], r[15:8]};
			cpu_model_inst.acc(0, 0, 0);
			cpu_model_inst.acc(0, 1, 0);
		end
		$display("test pair ends");
		r = lfsr(r);
		@(posedge clk) #1 {pl, pw} = {1'b1, r[15:0]};
		@(posedge clk) #1 pl = 0;
		cmp(pv, r[15:0]);
		q = {q, r[7:0], r[15:8]};
		cpu_model_inst.acc(0, 0, 0);
		r = lfsr(r);
		@(posedge clk) #1 {pl, pw} = {1'b1, r[15:0]};
		@(posedge clk) #1 pl = 0;
		cpu_model_inst.acc(0, 1, 0);
		cmp(pv, r[15:0]);
		$display("test load ends");
		q.push_back(8'h5a);
		cpu_model_inst.acc(1, 2, 8'h5a);
		cpu_model_inst.acc(0, 2, 0);
		cpu_model_inst.acc(1, 1, 8'h77);
		cmp(pv, 16'h775a);
		cmp(pc, 1'b1);
		q.push_back(8'h00);
		cpu_model_inst.acc(1, 3, 8'hff);
		cpu_model_inst.acc(0, 3, 0);
		cmp(pv, 16'h775a);
		$display("test temp ends");
		repeat (3) @(posedge clk);
		conclude;
	end
	initial begin
		#20000 n_mismatch++;
		conclude;
	end
endmodule
